// *** inc/pei_pkg.sv ***
// Contract
// - the live status register shows the present level of every source, whatever the interrupt enable holds.
// - live status bits are: 7 pll1 lock lost, 6 pll1 input lost, 5 pll1 calibrating, 4..2 same for pll2, 1 pll1 switch back, 0 pll2 switch back.
// - when pll1 unlocks because its input was lost, only the pll1 input-lost bit is set and pll1 lock lost reads 0.
// - when pll2 unlocks because its input was lost, only the pll2 input-lost bit is set and pll2 lock lost reads 0.
// - each switch-back source shows an automatic change from secondary to primary reference of its pll.
// - a source whose mask bit is 1 does not help activate the interrupt.
// - the mask register uses the same bit order as the live status register.
// - mask bits are read-write, reset to 0, and load their start-up value from nonvolatile configuration.
// - with polarity 1 a rising edge on a source sets its latched flag.
// - with polarity 0 a falling edge on a source sets its latched flag.
// - the polarity register follows the live status bit order, read-write, reset to 0.
// - latched flags update only while the interrupt enable is 1.
// - a latched flag stays set until software writes 0 to it.
// - combine 1 asserts the interrupt only when all unmasked flags are set; combine 0 when any is set.
// - with interrupt enable 0 no interrupt is signalled while live status keeps tracking.
package pei_pkg;
  localparam int unsigned NSRC = 8;
  // printed offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_LIVE = 8'h0d;
  localparam logic [7:0] IDX_MASK = 8'h0e;
  localparam logic [7:0] IDX_POL = 8'h0f;
  localparam logic [7:0] IDX_FLAG = 8'h10;
  localparam logic [7:0] IDX_CTL = 8'h11;
  localparam logic [11:0] ADDR_LIVE = {2'b00, IDX_LIVE, 2'b00};
  localparam logic [11:0] ADDR_MASK = {2'b00, IDX_MASK, 2'b00};
  localparam logic [11:0] ADDR_POL = {2'b00, IDX_POL, 2'b00};
  localparam logic [11:0] ADDR_FLAG = {2'b00, IDX_FLAG, 2'b00};
  localparam logic [11:0] ADDR_CTL = {2'b00, IDX_CTL, 2'b00};
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam int unsigned BIT_PLL1_LOCK_LOST = 7;
  localparam int unsigned BIT_PLL1_INPUT_LOST = 6;
  localparam int unsigned BIT_PLL1_CALIBRATING = 5;
  localparam int unsigned BIT_PLL2_LOCK_LOST = 4;
  localparam int unsigned BIT_PLL2_INPUT_LOST = 3;
  localparam int unsigned BIT_PLL2_CALIBRATING = 2;
  localparam int unsigned BIT_PLL1_REF_SWITCH = 1;
  localparam int unsigned BIT_PLL2_REF_SWITCH = 0;
  localparam int unsigned BIT_CTL_AND_OR = 1;
  localparam int unsigned BIT_CTL_INT_EN = 0;
endpackage

// *** inc/pei_src_if.sv ***
`timescale 1ns/10ps
// synchronised sources and edge pulses between sampler and top
interface pei_src_if #(parameter int unsigned N = 8);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// *** design/pei_sync_edge.sv ***
`timescale 1ns/10ps
module pei_sync_edge #(
  parameter int unsigned N = 8
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_ce, // clock enable
  input wire logic [N-1:0] i_raw, // raw source levels
  pei_src_if.src o_src // synced level and edges
);
  logic [N-1:0] meta_r, meta_nxt;
  logic [N-1:0] sync_r, sync_nxt;
  logic [N-1:0] prev_r, prev_nxt;
  logic [N-1:0] lvl;

  // input lost wins over lock lost; gated behind the second flop so no logic reads a settling bit
  always_comb begin
    lvl = sync_r;
    lvl[pei_pkg::BIT_PLL1_LOCK_LOST] = sync_r[pei_pkg::BIT_PLL1_LOCK_LOST]
      & ~sync_r[pei_pkg::BIT_PLL1_INPUT_LOST];
    lvl[pei_pkg::BIT_PLL2_LOCK_LOST] = sync_r[pei_pkg::BIT_PLL2_LOCK_LOST]
      & ~sync_r[pei_pkg::BIT_PLL2_INPUT_LOST];
  end

  always_comb begin
    meta_nxt = i_ce ? i_raw : meta_r;
    sync_nxt = i_ce ? meta_r : sync_r;
    prev_nxt = i_ce ? lvl : prev_r;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // edges gated by ce so a frozen block sees no stale pulse
  assign o_src.level = lvl;
  assign o_src.rise = {N{i_ce}} & lvl & ~prev_r;
  assign o_src.fall = {N{i_ce}} & ~lvl & prev_r;
endmodule

// *** design/pei_combine.sv ***
`timescale 1ns/10ps
module pei_combine #(
  parameter int unsigned N = 8
) (
  input wire logic [N-1:0] i_flag, // latched flags
  input wire logic [N-1:0] i_mask, // 1 masks a flag
  input wire logic i_and_mode, // 1 and, 0 or
  input wire logic i_int_en, // interrupt enable
  output logic o_irq // combined request, unregistered
);
  logic [N-1:0] act;
  always_comb begin
    act = i_flag & ~i_mask;
    // and over unmasked flags; all masked gives no interrupt
    if (i_and_mode) begin
      o_irq = i_int_en && ((i_flag | i_mask) == {N{1'b1}}) && (i_mask != {N{1'b1}});
    end else begin
      o_irq = i_int_en && (act != '0);
    end
  end
endmodule

// *** design/pei_top.sv ***
`timescale 1ns/10ps
module pei_top (
  input wire logic i_clk_sys, // 10 MHz system clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic i_pll1_lock_lost, // pll1 lock lost detector
  input wire logic i_pll1_input_lost, // pll1 input lost detector
  input wire logic i_pll1_calibrating, // pll1 vco calibration active
  input wire logic i_pll2_lock_lost, // pll2 lock lost detector
  input wire logic i_pll2_input_lost, // pll2 input lost detector
  input wire logic i_pll2_calibrating, // pll2 vco calibration active
  input wire logic i_pll1_ref_switch_back, // pll1 auto switch to primary
  input wire logic i_pll2_ref_switch_back, // pll2 auto switch to primary
  input wire logic i_nv_load, // pulse: load nonvolatile config
  input wire logic [7:0] i_nv_mask, // nonvolatile mask image
  input wire logic [7:0] i_nv_pol, // nonvolatile polarity image
  input wire logic [1:0] i_nv_ctl, // nonvolatile and/or, enable image
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic o_irq // combined interrupt, active high
);
  logic [7:0] raw;
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] pol_r, pol_nxt;
  logic [7:0] flag_r, flag_nxt;
  logic and_or_r, and_or_nxt;
  logic int_en_r, int_en_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic irq_comb;
  logic [7:0] edge_hit;
  logic setup, wr, rd, hit;

  pei_src_if #(.N(pei_pkg::NSRC)) src_bus ();

  // plain bit placement only; precedence is applied after synchronising
  always_comb begin
    raw = '0;
    raw[pei_pkg::BIT_PLL1_INPUT_LOST] = i_pll1_input_lost;
    raw[pei_pkg::BIT_PLL1_LOCK_LOST] = i_pll1_lock_lost;
    raw[pei_pkg::BIT_PLL1_CALIBRATING] = i_pll1_calibrating;
    raw[pei_pkg::BIT_PLL2_INPUT_LOST] = i_pll2_input_lost;
    raw[pei_pkg::BIT_PLL2_LOCK_LOST] = i_pll2_lock_lost;
    raw[pei_pkg::BIT_PLL2_CALIBRATING] = i_pll2_calibrating;
    raw[pei_pkg::BIT_PLL1_REF_SWITCH] = i_pll1_ref_switch_back;
    raw[pei_pkg::BIT_PLL2_REF_SWITCH] = i_pll2_ref_switch_back;
  end

  pei_sync_edge #(.N(pei_pkg::NSRC)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_raw(raw),
    .o_src(src_bus.src)
  );

  pei_combine #(.N(pei_pkg::NSRC)) u_comb (
    .i_flag(flag_r),
    .i_mask(mask_r),
    .i_and_mode(and_or_r),
    .i_int_en(int_en_r),
    .o_irq(irq_comb)
  );

  // per-source edge select
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_edge
      assign edge_hit[g] = pol_r[g] ? src_bus.rise[g] : src_bus.fall[g];
    end
  endgenerate

  assign setup = psel && !penable;
  assign wr = psel && penable && pready_r && pwrite;
  assign rd = setup && !pwrite;
  always_comb begin
    unique case (paddr)
      pei_pkg::ADDR_LIVE, pei_pkg::ADDR_MASK, pei_pkg::ADDR_POL,
      pei_pkg::ADDR_FLAG, pei_pkg::ADDR_CTL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // register state
  always_comb begin
    mask_nxt = mask_r;
    pol_nxt = pol_r;
    flag_nxt = flag_r;
    and_or_nxt = and_or_r;
    int_en_nxt = int_en_r;
    if (i_nv_load) begin
      mask_nxt = i_nv_mask;
      pol_nxt = i_nv_pol;
      and_or_nxt = i_nv_ctl[pei_pkg::BIT_CTL_AND_OR];
      int_en_nxt = i_nv_ctl[pei_pkg::BIT_CTL_INT_EN];
    end else if (wr) begin
      if (paddr == pei_pkg::ADDR_MASK) begin
        mask_nxt = pwdata[7:0];
      end
      if (paddr == pei_pkg::ADDR_POL) begin
        pol_nxt = pwdata[7:0];
      end
      if (paddr == pei_pkg::ADDR_CTL) begin
        and_or_nxt = pwdata[pei_pkg::BIT_CTL_AND_OR];
        int_en_nxt = pwdata[pei_pkg::BIT_CTL_INT_EN];
      end
    end
    // writing 0 clears a flag, writing 1 leaves it
    if (wr && paddr == pei_pkg::ADDR_FLAG) begin
      flag_nxt = flag_r & pwdata[7:0];
    end
    // set beats a same-cycle clear
    if (int_en_r) begin
      flag_nxt = flag_nxt | edge_hit;
    end
  end

  // apb answer: no wait state, data ready in the first access cycle
  always_comb begin
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    irq_nxt = irq_comb;
    if (setup) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !hit;
      prdata_nxt = '0;
      if (rd) begin
        unique case (paddr)
          pei_pkg::ADDR_LIVE: prdata_nxt = {24'h00_0000, src_bus.level};
          pei_pkg::ADDR_MASK: prdata_nxt = {24'h00_0000, mask_r};
          pei_pkg::ADDR_POL: prdata_nxt = {24'h00_0000, pol_r};
          pei_pkg::ADDR_FLAG: prdata_nxt = {24'h00_0000, flag_r};
          pei_pkg::ADDR_CTL: prdata_nxt = {30'h0000_0000, and_or_r, int_en_r};
          default: prdata_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_r <= pei_pkg::RST_MASK;
      pol_r <= pei_pkg::RST_POL;
      flag_r <= pei_pkg::RST_FLAG;
      and_or_r <= 1'b0;
      int_en_r <= 1'b0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (i_ce) begin
      mask_r <= mask_nxt;
      pol_r <= pol_nxt;
      flag_r <= flag_nxt;
      and_or_r <= and_or_nxt;
      int_en_r <= int_en_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign o_irq = irq_r;
endmodule

// *** sim/pei_checker.sv ***
`timescale 1ns/10ps
module pei_checker (
  input wire logic i_clk_sys, i_rst_b, i_ce, i_nv_load, psel, penable, pwrite, pready, o_irq, // control
  input wire logic i_pll1_lock_lost, i_pll1_input_lost, i_pll1_calibrating, i_pll2_lock_lost, // sources
  input wire logic i_pll2_input_lost, i_pll2_calibrating, i_pll1_ref_switch_back, i_pll2_ref_switch_back, // sources
  input wire logic [7:0] i_nv_mask, i_nv_pol, // nv images
  input wire logic [1:0] i_nv_ctl, // nv control
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, prdata // apb data
);
  logic [7:0] lv, lv1_r, lv2_r, lv3_r, mask_r, pol_r;
  logic [1:0] ctl_r;
  logic bz_r, rd, wr;
  // lock lost hidden while input lost is up
  assign lv = {i_pll1_lock_lost & ~i_pll1_input_lost, i_pll1_input_lost, i_pll1_calibrating,
    i_pll2_lock_lost & ~i_pll2_input_lost, i_pll2_input_lost, i_pll2_calibrating, i_pll1_ref_switch_back,
    i_pll2_ref_switch_back};
  assign rd = psel && penable && pready && !pwrite;
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {lv1_r, lv2_r, lv3_r, mask_r, pol_r, ctl_r, bz_r} <= '0;
    end else if (i_ce) begin
      {lv1_r, lv2_r, lv3_r} <= {lv, lv1_r, lv2_r};
      // o_irq may lag a write or load by one cycle
      bz_r <= (psel && pwrite) || i_nv_load;
      if (i_nv_load) {mask_r, pol_r, ctl_r} <= {i_nv_mask, i_nv_pol, i_nv_ctl};
      else if (wr && paddr == pei_pkg::ADDR_MASK) mask_r <= pwdata[7:0];
      else if (wr && paddr == pei_pkg::ADDR_POL) pol_r <= pwdata[7:0];
      else if (wr && paddr == pei_pkg::ADDR_CTL) ctl_r <= pwdata[1:0];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  property p_answer; psel && !penable && i_ce |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_live; rd && paddr == pei_pkg::ADDR_LIVE && lv == lv1_r && lv1_r == lv2_r && lv2_r == lv3_r
    |-> prdata == {24'h00_0000, lv3_r}; endproperty
  a_live: assert property (p_live) else $error("live status wrong");
  property p_mask; rd && paddr == pei_pkg::ADDR_MASK |-> prdata == {24'h00_0000, mask_r}; endproperty
  a_mask: assert property (p_mask) else $error("mask readback wrong");
  property p_off; !ctl_r[0] && !$past(ctl_r[0]) |-> !o_irq; endproperty
  a_off: assert property (p_off) else $error("irq while disabled");
  property p_masked; mask_r == 8'hff && $past(mask_r) == 8'hff |-> !o_irq; endproperty
  a_masked: assert property (p_masked) else $error("irq with all masked");
  property p_hold; o_irq && !(psel && pwrite) && !i_nv_load && !bz_r |=> o_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped without write");
  property p_rise; i_ce && ctl_r == 2'b01 && |(lv & ~lv1_r & pol_r & ~mask_r) |-> ##[1:6] o_irq; endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  property p_fall; i_ce && ctl_r == 2'b01 && |(~lv & lv1_r & ~pol_r & ~mask_r) |-> ##[1:6] o_irq; endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  c_irq: cover property (o_irq);
  c_and: cover property (ctl_r == 2'b11 && o_irq);
  c_live: cover property (rd && paddr == pei_pkg::ADDR_LIVE && prdata != 32'h0000_0000);
endmodule
bind pei_top pei_checker u_pei_checker (.*);

// *** sim/pei_pll_model.sv ***
`timescale 1ns/10ps
// stands in for the pll detectors; levels move just after an edge
module pei_pll_model (
  input wire logic i_clk_sys, // system clock
  input wire logic i_slow, // 1 adds one cycle of detector lag
  input wire logic [7:0] i_want, // wanted levels, live status order
  output logic [7:0] o_lvl = 8'h00 // detector outputs
);
  logic [7:0] lag_r = 8'h00;
  always @(posedge i_clk_sys) begin
    lag_r <= i_want;
    o_lvl <= i_slow ? lag_r : i_want;
  end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] x; logic err;} pei_row_t;
  logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_nv_load = 1'b0, slow = 1'b0, ce = 1'b1, e;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, o_irq;
  logic [7:0] want = 8'h00, lvl;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  int miscompares = 0, checks_done = 0;
  pei_row_t rows [6] = '{
    '{pei_pkg::ADDR_MASK, 8'ha5, 8'ha5, 1'b0}, '{pei_pkg::ADDR_POL, 8'h5a, 8'h5a, 1'b0},
    '{pei_pkg::ADDR_LIVE, 8'hff, 8'h00, 1'b0}, '{12'h048, 8'hff, 8'h00, 1'b1},
    '{pei_pkg::ADDR_MASK, 8'h00, 8'h00, 1'b0}, '{pei_pkg::ADDR_POL, 8'h00, 8'h00, 1'b0}};
  pei_pll_model u_pei_pll_model (.i_clk_sys(i_clk_sys), .i_slow(slow), .i_want(want), .o_lvl(lvl));
  pei_top u_pei_top (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(ce), .i_pll1_lock_lost(lvl[7]),
    .i_pll1_input_lost(lvl[6]), .i_pll1_calibrating(lvl[5]), .i_pll2_lock_lost(lvl[4]),
    .i_pll2_input_lost(lvl[3]), .i_pll2_calibrating(lvl[2]), .i_pll1_ref_switch_back(lvl[1]),
    .i_pll2_ref_switch_back(lvl[0]), .i_nv_load(i_nv_load), .i_nv_mask(8'h11), .i_nv_pol(8'h22),
    .i_nv_ctl(2'b00), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_irq(o_irq));
  initial forever #50 i_clk_sys = ~i_clk_sys;
  task automatic ck(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic ap(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    // look half a period before the edge so the launching edge never races the check
    do @(negedge i_clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    @(posedge i_clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    ap(a, 1'b0, 32'h0000_0000);
    ck(r, {24'h00_0000, x});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    ap(a, 1'b1, {24'h00_0000, d});
  endtask
  task automatic src(input logic [7:0] v);
    want <= v;
    repeat (8) @(posedge i_clk_sys);
  endtask
  task automatic irq(input logic x);
    repeat (3) @(negedge i_clk_sys);
    ck({31'h0000_0000, o_irq}, {31'h0000_0000, x});
    @(posedge i_clk_sys);
  endtask
  task automatic test_done;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300_000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    rd(pei_pkg::ADDR_MASK, 8'h00);
    rd(pei_pkg::ADDR_POL, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      ap(rows[i].a, 1'b0, 32'h0000_0000);
      ck(r, {24'h00_0000, rows[i].x});
      ck({31'h0000_0000, e}, {31'h0000_0000, rows[i].err});
    end
    src(8'ha7);
    rd(pei_pkg::ADDR_LIVE, 8'ha7);
    src(8'hc0);
    rd(pei_pkg::ADDR_LIVE, 8'h40);
    src(8'h18);
    rd(pei_pkg::ADDR_LIVE, 8'h08);
    src(8'h03);
    rd(pei_pkg::ADDR_LIVE, 8'h03);
    rd(pei_pkg::ADDR_FLAG, 8'h00);
    irq(1'b0);
    wr(pei_pkg::ADDR_CTL, 8'h01);
    src(8'h00);
    rd(pei_pkg::ADDR_FLAG, 8'h03);
    wr(pei_pkg::ADDR_FLAG, 8'h01);
    rd(pei_pkg::ADDR_FLAG, 8'h01);
    wr(pei_pkg::ADDR_FLAG, 8'h00);
    irq(1'b0);
    // a pulse that comes and goes while frozen must leave no flag
    ce <= 1'b0;
    src(8'h01);
    src(8'h00);
    ce <= 1'b1;
    rd(pei_pkg::ADDR_FLAG, 8'h00);
    wr(pei_pkg::ADDR_POL, 8'hff);
    slow <= 1'b1;
    src(8'h20);
    rd(pei_pkg::ADDR_FLAG, 8'h20);
    irq(1'b1);
    wr(pei_pkg::ADDR_MASK, 8'h20);
    irq(1'b0);
    wr(pei_pkg::ADDR_CTL, 8'h03);
    irq(1'b0);
    wr(pei_pkg::ADDR_MASK, 8'hdf);
    irq(1'b1);
    wr(pei_pkg::ADDR_CTL, 8'h02);
    irq(1'b0);
    i_nv_load <= 1'b1;
    @(posedge i_clk_sys);
    i_nv_load <= 1'b0;
    rd(pei_pkg::ADDR_MASK, 8'h11);
    rd(pei_pkg::ADDR_POL, 8'h22);
    rd(pei_pkg::ADDR_CTL, 8'h00);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    rd(pei_pkg::ADDR_MASK, 8'h00);
    rd(pei_pkg::ADDR_POL, 8'h00);
    irq(1'b0);
    test_done;
  end
endmodule
